// [cpu_core_model.sv]
// CPU core model that answers vector fetches with the fetch address plus HANDLER_OFS.
// Assumes the fetch request holds until the entry pulse has been seen.
module cpu_core_model
#(
  parameter logic [23:0] HANDLER_OFS = 24'h001000
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic        fetch_req_i,
  input  wire logic [23:0] fetch_addr_i,
  output logic             entry_valid_o,
  output logic      [23:0] entry_data_o
);
  logic [3:0] wait_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_r        <= 4'h0;
      entry_valid_o <= 1'b0;
      entry_data_o  <= 24'h000000;
    end
    else
    begin
      // Off the pulse the data toggles, so a stale entry still matches on every second cycle.
      entry_valid_o <= 1'b0;
      entry_data_o  <= ~entry_data_o;
      if (fetch_req_i && !entry_valid_o)
      begin
        wait_r <= wait_r + 4'h1;
        if (!slow_i || wait_r == 4'h6)
        begin
          entry_valid_o <= 1'b1;
          entry_data_o  <= fetch_addr_i + HANDLER_OFS;
          wait_r        <= 4'h0;
        end
      end
    end
  end
endmodule

// [reset_and_vector_map_logic_tb_top.sv]
// Bench of the vector map: reset entry, table addresses, bit positions
// and interrupt status. Assumes the CPU core model answers every fetch.
module reset_and_vector_map_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vector_map_pkg::*;
  localparam logic [23:0] OFS = 24'h001000;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, ev, slow = 1'b0, fr, pl, vt, ack_o, irq_o;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0, trap_i = 4'h0, ipl_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [95:0] src_i = '0;
  logic [23:0] ed, fa, pv;
  logic [6:0]  vn;
  int          n_mismatch = 0, compares = 0, cycles = 0;

  always #2.5 clk_i = ~clk_i;

  vector_map DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .src_i(src_i),
    .trap_i(trap_i), .ipl_i(ipl_i), .entry_valid_i(ev),
    .entry_data_i(ed), .fetch_req_o(fr), .fetch_addr_o(fa),
    .vec_num_o(vn), .vec_trap_o(vt), .pc_load_o(pl), .pc_value_o(pv),
    .irq_o(irq_o));

  cpu_core_model #(.HANDLER_OFS(OFS)) cpu (.clk_i(clk_i), .rst_i(rst_i),
    .slow_i(slow), .fetch_req_i(fr), .fetch_addr_i(fa),
    .entry_valid_o(ev), .entry_data_o(ed));

  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] idx,
                    input logic [15:0] wd);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {16'h0000, wd};
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [15:0] e);
    wb(1'b0, idx, 16'h0000);
    chk("read data", {16'h0000, e}, rd);
  endtask

  task automatic arm(input int n, input logic [15:0] p);
    wb(1'b1, IDX_EN + 6'(n / 16), 16'(1 << (n % 16)));
    wb(1'b1, IDX_PRIO + 6'(n / 4), 16'(p << (4 * (n % 4))));
  endtask

  task automatic clean(input int n);
    wb(1'b1, IDX_FLAG + 6'(n / 16), 16'h0000);
    wb(1'b1, IDX_EN + 6'(n / 16), 16'h0000);
    ipl_i <= 4'h0;
  endtask

  task automatic entry(input logic [23:0] a, input int v, input logic t);
    do @(negedge clk_i); while (fr !== 1'b1);
    chk("fetch address", {8'h00, a}, {8'h00, fa});
    chk("vector number", 32'(v), {25'h0, vn});
    chk("trap table", {31'h0, t}, {31'h0, vt});
    do @(negedge clk_i); while (pl !== 1'b1);
    chk("pc value", {8'h00, a + OFS}, {8'h00, pv});
    @(posedge clk_i);
    ipl_i <= 4'h7;
  endtask

  task automatic user(input int n, input logic [23:0] base);
    arm(n, 16'h0001);
    src_i[n] <= 1'b1;
    entry(base + 24'(2 * n), n, 1'b0);
    src_i[n] <= 1'b0;
    clean(n);
  endtask

  task automatic reset_entry();
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk("pc load in reset", 32'h1, {31'h0, pl});
    chk("pc value in reset", 32'h0, {8'h00, pv});
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("pc load after release", 32'h1, {31'h0, pl});
    @(negedge clk_i);
    chk("pc load end", 32'h0, {31'h0, pl});
    chk("no reset fetch", 32'h0, {31'h0, fr});
    @(posedge clk_i);
  endtask

  task automatic traps(input logic [23:0] base);
    for (int t = 0; t < 4; t++)
    begin
      trap_i <= 4'(1 << t);
      @(posedge clk_i);
      trap_i <= 4'h0;
      entry(base + 24'(2 * (t + 1)), t + 1, 1'b1);
    end
    rdc(IDX_TRAP, 16'h001E);
    ipl_i <= 4'h0;
  endtask

  task automatic positions();
    wb(1'b1, IDX_EN + 6'h04, 16'hFFFF);
    rdc(IDX_EN + 6'h04, IMPL_MASK[79:64]);
    wb(1'b1, IDX_PRIO + 6'h13, 16'h7777);
    rdc(IDX_PRIO + 6'h13, 16'h0070);
    wb(1'b1, IDX_EN + 6'h04, 16'h0000);
    src_i[4] <= 1'b1;
    rdc(IDX_FLAG, 16'h0000);
    src_i[4] <= 1'b0;
    chk("no request", 32'h0, {31'h0, fr});
    rdc(6'h3F, 16'h0000);
  endtask

  task automatic tie();
    arm(37, 16'h0002);
    arm(62, 16'h0002);
    src_i[37] <= 1'b1;
    src_i[62] <= 1'b1;
    entry(USER_BASE + 24'd74, 37, 1'b0);
    src_i[37] <= 1'b0;
    clean(37);
    entry(USER_BASE + 24'd124, 62, 1'b0);
    src_i[62] <= 1'b0;
    clean(62);
  endtask

  task automatic irq_path();
    wb(1'b1, IDX_IMASK, 16'h0001);
    wb(1'b0, IDX_ISTAT, 16'h0000);
    user(13, USER_BASE);
    @(negedge clk_i);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    rdc(IDX_ISTAT, 16'h0001);
    @(negedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wb(1'b1, IDX_IMASK, 16'h0000);
    user(0, USER_BASE);
    @(negedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
  endtask

  initial
  begin
    reset_entry();
    traps(TRAP_BASE);
    user(0, USER_BASE);
    user(93, USER_BASE);
    positions();
    tie();
    irq_path();
    slow <= 1'b1;
    wb(1'b1, IDX_CTRL, 16'h0001);
    traps(TRAP_BASE + ALT_OFFSET);
    user(13, USER_BASE + ALT_OFFSET);
    wrap_up();
  end
endmodule

// [vector_map.sv]
// Vector addressing, request flags and reset entry for the CPU core.
// Assumes one clock, a Wishbone classic master and a CPU that answers
// each fetch request with one entry_valid_i pulse.
module vector_map
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [7:0]             adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output logic      [31:0]            dat_o,
  output logic                        ack_o,
  input  wire logic [95:0]            src_i,
  input  wire logic [3:0]             trap_i,
  input  wire logic [3:0]             ipl_i,
  input  wire logic                   entry_valid_i,
  input  wire logic [23:0]            entry_data_i,
  output logic                        fetch_req_o,
  output logic      [23:0]            fetch_addr_o,
  output logic      [6:0]             vec_num_o,
  output logic                        vec_trap_o,
  output logic                        pc_load_o,
  output logic      [23:0]            pc_value_o,
  output logic                        irq_o
);
  import vector_map_pkg::*;

  state_t                 st_r;
  state_t                 st_nxt;
  logic   [NUM_VEC-1:0]   req;
  logic                   best_ok;
  logic   [6:0]           best_num;
  logic   [2:0]           best_prio;
  logic                   trap_ok;
  logic   [1:0]           trap_num;
  logic   [5:0]           idx;
  logic                   acc;
  logic   [15:0]          wmask;
  logic   [15:0]          wword;

  assign idx   = adr_i[7:2];
  assign acc   = cyc_i && stb_i && !st_r.ack;
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  // A vector requests only when it has a source, is flagged, enabled and
  // carries a nonzero priority.
  genvar g;
  for (g = 0; g < NUM_VEC; g++)
  begin : g_req
    assign req[g] = IMPL_MASK[g] && st_r.flag[g] && st_r.en[g] &&
                    (st_r.prio[g] != 3'h0);
  end

  // Scanning from the top lets a lower vector take over a tie.
  always_comb
  begin
    best_ok   = 1'b0;
    best_num  = 7'h00;
    best_prio = 3'h0;
    for (int n = NUM_VEC - 1; n >= 0; n--)
    begin
      if (req[n] && st_r.prio[n] >= best_prio)
      begin
        best_ok   = 1'b1;
        best_num  = n[6:0];
        best_prio = st_r.prio[n];
      end
    end
    trap_ok  = 1'b0;
    trap_num = 2'h0;
    for (int t = NUM_TRAPS - 1; t >= 0; t--)
    begin
      if (st_r.trap_pend[t])
      begin
        trap_ok  = 1'b1;
        trap_num = t[1:0];
      end
    end
  end

  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.ack       = 1'b0;
    st_nxt.pc_load   = 1'b0;
    st_nxt.dat       = 32'h0000_0000;
    wword            = 16'h0000;

    // Register reads; unmapped words read zero.
    for (int w = 0; w < NUM_WORDS; w++)
    begin
      if (idx == IDX_FLAG + w[5:0])
        st_nxt.dat[15:0] = st_r.flag[w*16 +: 16];
      if (idx == IDX_EN + w[5:0])
        st_nxt.dat[15:0] = st_r.en[w*16 +: 16];
    end
    for (int w = 0; w < NUM_PWORDS; w++)
      if (idx == IDX_PRIO + w[5:0])
        for (int k = 0; k < 4; k++)
          st_nxt.dat[k*FIELD_W +: PRIO_W] = st_r.prio[w*4 + k];
    if (idx == IDX_CTRL)
      st_nxt.dat[CTRL_ALT] = st_r.alt;
    if (idx == IDX_TRAP)
      st_nxt.dat[4:1] = st_r.trap_stat;
    if (idx == IDX_ISTAT)
      st_nxt.dat[1:0] = st_r.ist;
    if (idx == IDX_IMASK)
      st_nxt.dat[1:0] = st_r.imask;
    if (idx == IDX_VSTAT)
      st_nxt.dat[9:0] = {st_r.vec_trap, st_r.fetch_req, st_r.vec_num};
    if (!acc)
      st_nxt.dat = 32'h0000_0000;
    else
      st_nxt.ack = 1'b1;

    // Register writes with byte lanes 0 and 1.
    if (acc && we_i)
    begin
      for (int w = 0; w < NUM_WORDS; w++)
      begin
        if (idx == IDX_FLAG + w[5:0])
          st_nxt.flag[w*16 +: 16] = (st_r.flag[w*16 +: 16] & ~wmask) |
                                    (dat_i[15:0] & wmask);
        if (idx == IDX_EN + w[5:0])
          st_nxt.en[w*16 +: 16] = (st_r.en[w*16 +: 16] & ~wmask) |
                                  (dat_i[15:0] & wmask);
      end
      for (int w = 0; w < NUM_PWORDS; w++)
      begin
        if (idx == IDX_PRIO + w[5:0])
        begin
          for (int k = 0; k < 4; k++)
            wword[k*FIELD_W +: PRIO_W] = st_r.prio[w*4 + k];
          wword = (wword & ~wmask) | (dat_i[15:0] & wmask);
          for (int k = 0; k < 4; k++)
            st_nxt.prio[w*4 + k] = wword[k*FIELD_W +: PRIO_W];
        end
      end
      if (idx == IDX_CTRL && sel_i[0])
        st_nxt.alt = dat_i[CTRL_ALT];
      if (idx == IDX_TRAP && sel_i[0])
        st_nxt.trap_stat = dat_i[4:1];
      if (idx == IDX_IMASK && sel_i[0])
        st_nxt.imask = dat_i[1:0];
    end
    if (acc && !we_i && idx == IDX_ISTAT)
      st_nxt.ist = 2'h0;

    // Hardware sets come after software writes so that a set wins.
    st_nxt.flag      = (st_nxt.flag | src_i) & IMPL_MASK;
    st_nxt.en        = st_nxt.en & IMPL_MASK;
    for (int n = 0; n < NUM_VEC; n++)
      if (!IMPL_MASK[n])
        st_nxt.prio[n] = 3'h0;
    st_nxt.trap_stat = st_nxt.trap_stat | trap_i;
    st_nxt.trap_pend = st_r.trap_pend | trap_i;
    if (trap_i != 4'h0)
      st_nxt.ist[EV_TRAP] = 1'b1;

    case (st_r.seq)
      ST_RESET:
        st_nxt.seq = ST_IDLE;
      ST_IDLE:
      begin
        if (trap_ok || (best_ok && {1'b0, best_prio} > ipl_i))
        begin
          st_nxt.seq       = ST_FETCH;
          st_nxt.fetch_req = 1'b1;
          st_nxt.vec_trap  = trap_ok;
          if (trap_ok)
          begin
            st_nxt.vec_num    = {3'h0, {2'b00, trap_num} + FIRST_TRAP};
            st_nxt.fetch_addr = TRAP_BASE +
                                {19'h0, {2'b00, trap_num} + FIRST_TRAP,
                                 1'b0};
          end
          else
          begin
            st_nxt.vec_num    = best_num;
            st_nxt.fetch_addr = USER_BASE + {16'h0, best_num, 1'b0};
          end
          if (st_r.alt)
            st_nxt.fetch_addr = st_nxt.fetch_addr + ALT_OFFSET;
        end
      end
      ST_FETCH:
      begin
        if (entry_valid_i)
        begin
          st_nxt.seq            = ST_LOAD;
          st_nxt.fetch_req      = 1'b0;
          st_nxt.pc_load        = 1'b1;
          st_nxt.pc_value       = entry_data_i;
          st_nxt.ist[EV_ENTRY]  = 1'b1;
          if (st_r.vec_trap)
            st_nxt.trap_pend[st_r.vec_num[1:0] - 2'h1] = 1'b0;
        end
      end
      ST_LOAD:
        st_nxt.seq = ST_IDLE;
      default:
        st_nxt.seq = ST_IDLE;
    endcase
    st_nxt.irq = |(st_nxt.ist & st_nxt.imask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r          <= '0;
      st_r.seq      <= ST_RESET;
      st_r.pc_load  <= 1'b1;
      st_r.pc_value <= RESET_PC;
    end
    else
      st_r <= st_nxt;
  end

  assign dat_o        = st_r.dat;
  assign ack_o        = st_r.ack;
  assign fetch_req_o  = st_r.fetch_req;
  assign fetch_addr_o = st_r.fetch_addr;
  assign vec_num_o    = st_r.vec_num;
  assign vec_trap_o   = st_r.vec_trap;
  assign pc_load_o    = st_r.pc_load;
  assign pc_value_o   = st_r.pc_value;
  assign irq_o        = st_r.irq;

  // Checks: a lower vector with the same or higher priority must not wait.
  logic beaten;
  always_comb
  begin
    beaten = 1'b0;
    for (int n = 0; n < NUM_VEC; n++)
      if (req[n] && n < best_num && st_r.prio[n] >= best_prio)
        beaten = 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking

  sequence fetch_start;
    $rose(fetch_req_o);
  endsequence

  sequence entry_taken;
    fetch_req_o && entry_valid_i;
  endsequence

  reset_pc_zero_a: assert property (rst_i |=> pc_load_o && pc_value_o == 24'h0)
    else $error("Reset did not force the program counter to zero.");

  reset_no_fetch_a: assert property (rst_i |=> !fetch_req_o[*2])
    else $error("A vector fetch was made for reset.");

  release_start_a: assert property (disable iff (rst_i)
    $fell(rst_i) |-> pc_load_o && pc_value_o == 24'h0 ##1 !pc_load_o)
    else $error("Execution did not start at address zero after reset.");

  trap_addr_a: assert property (disable iff (rst_i)
    fetch_start and vec_trap_o |-> fetch_addr_o ==
    24'h4 + {16'h0, vec_num_o, 1'b0} + (st_r.alt ? 24'h100 : 24'h0))
    else $error("Trap vector fetched from the wrong address.");

  user_addr_a: assert property (disable iff (rst_i)
    fetch_start and !vec_trap_o |-> fetch_addr_o ==
    24'h14 + {16'h0, vec_num_o, 1'b0} + (st_r.alt ? 24'h100 : 24'h0))
    else $error("User vector fetched from the wrong address.");

  alt_table_a: assert property (disable iff (rst_i)
    fetch_start and st_r.alt |-> fetch_addr_o[8])
    else $error("Alternate table select was not honoured.");

  tie_order_a: assert property (disable iff (rst_i)
    st_r.seq == ST_IDLE && best_ok && !trap_ok |-> !beaten)
    else $error("A higher vector won over a lower one of equal priority.");

  entry_load_a: assert property (disable iff (rst_i)
    entry_taken |=> pc_load_o && pc_value_o == $past(entry_data_i)
    ##1 !pc_load_o)
    else $error("Table entry was not loaded into the program counter.");

  unused_zero_a: assert property (disable iff (rst_i)
    (st_r.flag & ~IMPL_MASK) == 96'h0 && (st_r.en & ~IMPL_MASK) == 96'h0)
    else $error("A vector without source holds a flag or enable.");

endmodule

// [vector_map_pkg.sv]
// Constants, register map and types of the reset and vector map block.
// Assumes a 200 MHz system clock and a CPU core that fetches table entries.
package vector_map_pkg;

  localparam int          NUM_VEC    = 96;
  localparam int          NUM_WORDS  = 6;
  localparam int          NUM_PWORDS = 24;
  localparam int          NUM_TRAPS  = 4;
  // Vectors that have a peripheral source behind them.
  localparam logic [95:0] IMPL_MASK  = 96'h3FBE_210E_4066_3FE3_FFDF_3FEF;

  localparam logic [23:0] RESET_PC   = 24'h000000;
  localparam logic [23:0] TRAP_BASE  = 24'h000004;
  localparam logic [23:0] USER_BASE  = 24'h000014;
  localparam logic [23:0] ALT_OFFSET = 24'h000100;
  localparam logic [3:0]  FIRST_TRAP = 4'h1;

  // Word indices on the bus; byte address is four times the index.
  localparam logic [5:0]  IDX_FLAG   = 6'h00;
  localparam logic [5:0]  IDX_EN     = 6'h06;
  localparam logic [5:0]  IDX_PRIO   = 6'h0C;
  localparam logic [5:0]  IDX_CTRL   = 6'h24;
  localparam logic [5:0]  IDX_TRAP   = 6'h25;
  localparam logic [5:0]  IDX_ISTAT  = 6'h26;
  localparam logic [5:0]  IDX_IMASK  = 6'h27;
  localparam logic [5:0]  IDX_VSTAT  = 6'h28;

  localparam int          CTRL_ALT   = 0;
  localparam int          EV_ENTRY   = 0;
  localparam int          EV_TRAP    = 1;
  localparam int          PRIO_W     = 3;
  localparam int          FIELD_W    = 4;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_IDLE  = 2'b01,
    ST_FETCH = 2'b10,
    ST_LOAD  = 2'b11
  } seq_t;

  typedef struct packed
  {
    seq_t                        seq;
    logic [NUM_VEC-1:0]          flag;
    logic [NUM_VEC-1:0]          en;
    logic [NUM_VEC-1:0][2:0]     prio;
    logic                        alt;
    logic [NUM_TRAPS-1:0]        trap_stat;
    logic [NUM_TRAPS-1:0]        trap_pend;
    logic [1:0]                  ist;
    logic [1:0]                  imask;
    logic                        ack;
    logic [31:0]                 dat;
    logic                        pc_load;
    logic [23:0]                 pc_value;
    logic                        fetch_req;
    logic [23:0]                 fetch_addr;
    logic [6:0]                  vec_num;
    logic                        vec_trap;
    logic                        irq;
  } state_t;

endpackage
